// *** hw/uart_rx_pkg.sv ***
// constants, types and register map for the serial receiver with address filter
package uart_rx_pkg;

  // ************************************************************
  // register offsets on the plain register port
  // ************************************************************
  localparam logic [2:0] OFS_CTRL  = 3'h0;
  localparam logic [2:0] OFS_DATA  = 3'h1;
  localparam logic [2:0] OFS_PWR   = 3'h2;
  localparam logic [2:0] OFS_SLAVE_ADDR_REG = 3'h3;
  localparam logic [2:0] OFS_SMASK = 3'h4;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned CTRL_B7  = 7;
  localparam int unsigned CTRL_MLO = 6;
  localparam int unsigned CTRL_MPE = 5;
  localparam int unsigned CTRL_REN = 4;
  localparam int unsigned CTRL_RB8 = 2;
  localparam int unsigned CTRL_RI  = 0;
  localparam int unsigned PWR_SEL  = 6;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] PWR_RST   = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_REG_RST = 8'h00;
  localparam logic [7:0] SMASK_RST = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;

  // ************************************************************
  // oversampling and frame counts
  // ************************************************************
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [3:0] SAMPLE_A  = 4'h7;
  localparam logic [3:0] SAMPLE_B  = 4'h8;
  localparam logic [3:0] SAMPLE_C  = 4'h9;
  localparam logic [3:0] NBITS_8   = 4'h8;
  localparam logic [3:0] NBITS_9   = 4'h9;

  // ************************************************************
  // modes, states and carriers
  // ************************************************************
  localparam logic [1:0] MODE_SHIFT = 2'b00;
  localparam logic [1:0] MODE_8VAR  = 2'b01;
  localparam logic [1:0] MODE_9FIX  = 2'b10;
  localparam logic [1:0] MODE_9VAR  = 2'b11;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  typedef struct packed {
    logic valid;
    logic value;
  } bit_s;

endpackage

// *** hw/rx_bit_sampler.sv ***
// oversampling phase counter and 2-of-3 bit voter
`timescale 1ns/1ps
module rx_bit_sampler (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // oversampling tick and line
  input  wire logic             tick_i,
  input  wire logic             align_i,
  input  wire logic             line_i,
  // voted bit and phase
  output uart_rx_pkg::bit_s     bit_o,
  output logic [3:0]            phase_o
);

  logic [3:0] phase_reg;
  logic       samp_a_reg;
  logic       samp_b_reg;
  uart_rx_pkg::bit_s bit_reg;

  function automatic logic vote(input logic a, input logic b, input logic c);
    vote = (a & b) | (a & c) | (b & c);
  endfunction

  // ************************************************************
  // divide-by-16 phase
  // ************************************************************
  // align on start
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      phase_reg <= uart_rx_pkg::PHASE_RST;
    end else if (align_i) begin
      phase_reg <= uart_rx_pkg::PHASE_RST;
    end else if (tick_i) begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  // ************************************************************
  // three samples and vote
  // ************************************************************
  // majority of three
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
      bit_reg    <= '0;
    end else begin
      bit_reg.valid <= 1'b0;
      if (tick_i && !align_i) begin
        if (phase_reg == uart_rx_pkg::SAMPLE_A) begin
          samp_a_reg <= line_i;
        end
        if (phase_reg == uart_rx_pkg::SAMPLE_B) begin
          samp_b_reg <= line_i;
        end
        if (phase_reg == uart_rx_pkg::SAMPLE_C) begin
          bit_reg.valid <= 1'b1;
          bit_reg.value <= vote(samp_a_reg, samp_b_reg, line_i);
        end
      end
    end
  end

  assign bit_o   = bit_reg;
  assign phase_o = phase_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_vote_phase: assert property (bit_reg.valid |-> phase_reg == 4'ha || $past(align_i))
    else $error("voted bit not taken at the ninth phase");

endmodule

// *** hw/uart_rx_addr_filter.sv ***
// serial receiver with framing check, multiprocessor filter and address match
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module uart_rx_addr_filter (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  // serial line and 16x tick
  input  wire logic       rxd_i,
  input  wire logic       baud16_tick_i,
  // status
  output logic            receive_done_o,
  output logic            frame_err_o
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] ctrl_sw_reg;
  logic [7:0] power_ctrl_reg;
  logic [7:0] slave_addr_reg;
  logic [7:0] slave_addr_mask;
  logic [7:0] serial_data_buffer;
  logic       received_extra_bit;
  logic       receive_done_flag;
  logic       frame_err_flag;
  logic [7:0] rdata_reg;
  logic       rx_meta_reg;
  logic       rx_sync_reg;
  logic       line_prev_reg;
  logic [8:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  uart_rx_pkg::rx_state_e state_reg;
  uart_rx_pkg::rx_state_e state_next;
  uart_rx_pkg::bit_s      voted;
  logic [3:0] phase;
  logic [1:0] mode;
  logic       bit7_function_select;
  logic       multiproc_enable;
  logic       nine_bit;
  logic       rx_enable;
  logic       start_edge;
  logic       final_shift;
  logic       stop_bit;
  logic [7:0] rx_byte;
  logic       addr_hit;
  logic       accept;
  logic       load;
  logic       load_extra;
  logic       wr_ctrl;
  logic [3:0] nbits;

  function automatic logic given_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
    given_match = ((b ^ a) & m) == 8'h00;
  endfunction

  function automatic logic bcast_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
    bcast_match = ((a | m) & ~b) == 8'h00;
  endfunction

  // ************************************************************
  // mode decode
  // ************************************************************
  // mode encoding
  assign mode     = {ctrl_sw_reg[uart_rx_pkg::CTRL_B7], ctrl_sw_reg[uart_rx_pkg::CTRL_MLO]};
  assign nine_bit = (mode == uart_rx_pkg::MODE_9FIX) || (mode == uart_rx_pkg::MODE_9VAR);
  assign nbits    = nine_bit ? uart_rx_pkg::NBITS_9 : uart_rx_pkg::NBITS_8;
  assign bit7_function_select = power_ctrl_reg[uart_rx_pkg::PWR_SEL];
  assign multiproc_enable     = ctrl_sw_reg[uart_rx_pkg::CTRL_MPE];
  assign rx_enable = ctrl_sw_reg[uart_rx_pkg::CTRL_REN] && (mode != uart_rx_pkg::MODE_SHIFT);
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == uart_rx_pkg::OFS_CTRL);

  // ************************************************************
  // line synchroniser and edge search
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rxd_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      line_prev_reg <= 1'b1;
    end else if (baud16_tick_i) begin
      line_prev_reg <= rx_sync_reg;
    end
  end

  assign start_edge = (state_reg == uart_rx_pkg::RX_IDLE) && rx_enable && baud16_tick_i
                      && line_prev_reg && !rx_sync_reg;

  rx_bit_sampler u_sampler (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (baud16_tick_i),
    .align_i   (start_edge),
    .line_i    (rx_sync_reg),
    .bit_o     (voted),
    .phase_o   (phase)
  );

  // ************************************************************
  // frame sequencer
  // ************************************************************
  // one path for all async modes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      uart_rx_pkg::RX_IDLE: begin
        if (start_edge) begin
          state_next = uart_rx_pkg::RX_START;
        end
      end
      uart_rx_pkg::RX_START: begin
        if (voted.valid) begin
          state_next = voted.value ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
        end
      end
      uart_rx_pkg::RX_DATA: begin
        if (voted.valid && (bit_cnt_reg == nbits - 4'h1)) begin
          state_next = uart_rx_pkg::RX_STOP;
        end
      end
      uart_rx_pkg::RX_STOP: begin
        if (voted.valid) begin
          state_next = uart_rx_pkg::RX_IDLE;
        end
      end
      default: begin
        state_next = uart_rx_pkg::RX_IDLE;
      end
    endcase
    // dropping the enable mid-frame abandons the frame silently
    if (!rx_enable) begin
      state_next = uart_rx_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= uart_rx_pkg::RX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      shift_reg   <= 9'h000;
      bit_cnt_reg <= 4'h0;
    end else if (state_reg == uart_rx_pkg::RX_START) begin
      bit_cnt_reg <= 4'h0;
    end else if ((state_reg == uart_rx_pkg::RX_DATA) && voted.valid) begin
      shift_reg   <= {voted.value, shift_reg[8:1]};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // ************************************************************
  // acceptance at the final shift
  // ************************************************************
  // final shift at mid stop bit
  assign final_shift = (state_reg == uart_rx_pkg::RX_STOP) && voted.valid && rx_enable;
  assign stop_bit    = voted.value;
  assign rx_byte     = nine_bit ? shift_reg[7:0] : shift_reg[8:1];
  assign addr_hit = given_match(rx_byte, slave_addr_reg, slave_addr_mask)
                    || bcast_match(rx_byte, slave_addr_reg, slave_addr_mask);

  always_comb begin
    if (receive_done_flag) begin
      accept = 1'b0;
    end else if (!multiproc_enable) begin
      accept = 1'b1;
    end else if (nine_bit) begin
      accept = shift_reg[8] && addr_hit;
    end else begin
      accept = stop_bit;
    end
  end

  assign load = final_shift && accept;
  // extra bit is the stop bit in 8-bit mode, the ninth data bit otherwise
  assign load_extra = nine_bit ? shift_reg[8] : stop_bit;

  // ************************************************************
  // receive results and flags
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      serial_data_buffer <= uart_rx_pkg::DATA_RST;
    end else if (load) begin
      serial_data_buffer <= rx_byte;
    end
  end

  // hardware load wins over a same-cycle software write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      received_extra_bit <= 1'b0;
      receive_done_flag  <= 1'b0;
    end else if (load) begin
      received_extra_bit <= load_extra;
      receive_done_flag  <= 1'b1;
    end else if (wr_ctrl) begin
      received_extra_bit <= reg_wdata_i[uart_rx_pkg::CTRL_RB8];
      receive_done_flag  <= reg_wdata_i[uart_rx_pkg::CTRL_RI];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      frame_err_flag <= 1'b0;
    end else if (final_shift && !stop_bit) begin
      frame_err_flag <= 1'b1;
    end else if (wr_ctrl && bit7_function_select) begin
      frame_err_flag <= reg_wdata_i[uart_rx_pkg::CTRL_B7];
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  // address and mask clear on reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_sw_reg     <= uart_rx_pkg::CTRL_RST;
      power_ctrl_reg  <= uart_rx_pkg::PWR_RST;
      slave_addr_reg  <= uart_rx_pkg::SLAVE_ADDR_REG_RST;
      slave_addr_mask <= uart_rx_pkg::SMASK_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        uart_rx_pkg::OFS_CTRL: begin
          // bit 7 hides mode bit when selected
          ctrl_sw_reg <= {bit7_function_select ? ctrl_sw_reg[7] : reg_wdata_i[7], reg_wdata_i[6:0]};
        end
        uart_rx_pkg::OFS_PWR: begin
          power_ctrl_reg <= reg_wdata_i;
        end
        uart_rx_pkg::OFS_SLAVE_ADDR_REG: begin
          slave_addr_reg <= reg_wdata_i;
        end
        uart_rx_pkg::OFS_SMASK: begin
          slave_addr_mask <= reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (!reg_rd_i) begin
      rdata_reg <= 8'h00;
    end else begin
      case (reg_addr_i)
        uart_rx_pkg::OFS_CTRL: begin
          rdata_reg <= {bit7_function_select ? frame_err_flag : ctrl_sw_reg[7], ctrl_sw_reg[6:3],
                        received_extra_bit, ctrl_sw_reg[1], receive_done_flag};
        end
        uart_rx_pkg::OFS_DATA:  rdata_reg <= serial_data_buffer;
        uart_rx_pkg::OFS_PWR:   rdata_reg <= power_ctrl_reg;
        uart_rx_pkg::OFS_SLAVE_ADDR_REG: rdata_reg <= slave_addr_reg;
        uart_rx_pkg::OFS_SMASK: rdata_reg <= slave_addr_mask;
        default:                rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o    = rdata_reg;
  assign receive_done_o = receive_done_flag;
  assign frame_err_o    = frame_err_flag;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fe_readback: assert property (
    reg_rd_i && reg_addr_i == uart_rx_pkg::OFS_CTRL && bit7_function_select && !wr_ctrl && !final_shift
    |=> reg_rdata_o[7] == frame_err_flag)
    else $error("control bit 7 does not show frame error");

  a_start_edge: assert property (
    state_reg == uart_rx_pkg::RX_IDLE ##1 state_reg == uart_rx_pkg::RX_START
    |-> $past(line_prev_reg) && !$past(rx_sync_reg) && $past(baud16_tick_i))
    else $error("frame started without falling edge");

  a_phase_align: assert property (
    start_edge |=> phase == uart_rx_pkg::PHASE_RST)
    else $error("phase not reset at start edge");

  a_false_start: assert property (
    state_reg == uart_rx_pkg::RX_START && voted.valid && voted.value |=> state_reg == uart_rx_pkg::RX_IDLE)
    else $error("false start not rejected");

  a_load_result: assert property (
    load |=> receive_done_flag && serial_data_buffer == $past(rx_byte) && received_extra_bit == $past(load_extra))
    else $error("accepted frame not loaded");

  a_reject_keep: assert property (
    final_shift && !accept |=> $stable(serial_data_buffer))
    else $error("rejected frame changed the buffer");

  a_addr_filter: assert property (
    load && multiproc_enable && nine_bit |-> shift_reg[8] && addr_hit)
    else $error("address byte accepted without match");

  a_fe_sticky: assert property (
    frame_err_flag && !wr_ctrl |=> frame_err_flag)
    else $error("frame error cleared without software");

  a_reset_addr: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    !rst_n_i |=> slave_addr_reg == 8'h00 && slave_addr_mask == 8'h00)
    else $error("address registers not cleared by reset");

  c_frame_taken: cover property (load);
  c_false_start: cover property (state_reg == uart_rx_pkg::RX_START ##1 state_reg == uart_rx_pkg::RX_IDLE);
  c_frame_error: cover property ($rose(frame_err_flag));
  c_addr_reject: cover property (final_shift && multiproc_enable && nine_bit && shift_reg[8] && !addr_hit);

endmodule

// *** tb/serial_tx_model.sv ***
// remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
module serial_tx_model (
  // clock and 16x tick
  input  wire logic       ref_clk_i,
  input  wire logic       tick_i,
  // frame request: bits after the start bit, lsb first
  input  wire logic       go_i,
  input  wire logic [9:0] frame_i,
  input  wire logic [3:0] len_i,
  input  wire logic       glitch_i,
  // line and status
  output logic            rxd_o,
  output logic            busy_o
);
  logic [9:0] shift_reg;
  logic [3:0] sub_reg;
  logic [4:0] left_reg;
  logic       glitch_reg;

  initial begin
    rxd_o = 1'b1;
    busy_o = 1'b0;
  end

  // ****
  // one frame per request, then one idle bit time
  // ****
  always @(posedge ref_clk_i) begin
    if (tick_i && !busy_o && go_i) begin
      busy_o     <= 1'b1;
      rxd_o      <= 1'b0;
      shift_reg  <= frame_i;
      left_reg   <= glitch_i ? 5'h00 : {1'b0, len_i} + 5'h01;
      glitch_reg <= glitch_i;
      sub_reg    <= 4'h0;
    end else if (tick_i && busy_o) begin
      sub_reg <= sub_reg + 4'h1;
      // noise pulse: low for four ticks only, must not start a frame
      if (glitch_reg && sub_reg == 4'h3) begin
        rxd_o <= 1'b1;
      end
      if (sub_reg == 4'hf) begin
        if (left_reg == 5'h00) begin
          busy_o <= 1'b0;
        end else begin
          rxd_o     <= shift_reg[0];
          shift_reg <= {1'b1, shift_reg[9:1]};
          left_reg  <= left_reg - 5'h01;
        end
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the serial receiver with address filter
`timescale 1ns/1ps
module testbench;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       rxd_i;
  logic       baud16_tick_i = 1'b0;
  logic       done;
  logic       ferr;
  string      rd_name;
  logic [7:0] rd_exp;
  logic       go;
  logic [9:0] frame;
  logic [3:0] len;
  logic       glitch;
  logic       busy;
  logic [1:0] tick_cnt = 2'h0;
  logic       rd_seen = 1'b0;
  logic [7:0] last_data;
  logic [7:0] b;
  logic [7:0] sa;
  logic [7:0] sm;
  logic [7:0] r;
  logic [1:0] m2;
  logic       nb;
  logic       xb;
  logic       acc;
  int         errors;
  int         checks;
  string      name_q[$];
  logic [7:0] exp_q[$];

  uart_rx_addr_filter uart_rx_addr_filter_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rxd_i(rxd_i), .baud16_tick_i(baud16_tick_i), .receive_done_o(done), .frame_err_o(ferr));
  serial_tx_model serial_tx_model_i (.ref_clk_i(ref_clk_i), .tick_i(baud16_tick_i), .go_i(go),
    .frame_i(frame), .len_i(len), .glitch_i(glitch), .rxd_o(rxd_i), .busy_o(busy));

  // ****
  // clock, 16x tick every fourth clock, read-result monitor
  // ****
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    tick_cnt      <= tick_cnt + 2'h1;
    baud16_tick_i <= (tick_cnt == 2'h3);
    rd_seen       <= reg_rd_i;
    if (rd_seen) begin
      rd_name = name_q.pop_front();
      rd_exp  = exp_q.pop_front();
      check(rd_name, reg_rdata_o, rd_exp);
      // the receive flag pin must agree with control bit 0
      if (rd_name == "ctrl") begin
        check("done", {7'h00, done}, {7'h00, rd_exp[0]});
      end
    end
  end

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] e);
    checks++;
    if (seen !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input string n, input logic [2:0] a, input logic [7:0] e);
    name_q.push_back(n);
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic send(input logic [9:0] f, input logic [3:0] n, input logic g);
    int k;
    @(posedge ref_clk_i);
    frame  <= f;
    len    <= n;
    glitch <= g;
    go     <= 1'b1;
    k = 0;
    while (!busy && k < 64) begin
      @(posedge ref_clk_i);
      k++;
    end
    go <= 1'b0;
    k = 0;
    while (busy && k < 4000) begin
      @(posedge ref_clk_i);
      k++;
    end
  endtask

  // sends one frame, then notes control and buffer as they must read
  task automatic expect_rx(input logic [9:0] f, input logic [3:0] n, input logic [7:0] c, input logic a);
    send(f, n, 1'b0);
    if (a) begin
      last_data = f[7:0];
    end
    rd("ctrl", uart_rx_pkg::OFS_CTRL, c);
    rd("data", uart_rx_pkg::OFS_DATA, last_data);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang cuts the run short well after the expected span
  initial begin
    #300000;
    errors++;
    close_out();
  end

  // ****
  // scenarios
  // ****
  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    go = 1'b0;
    frame = 10'h3ff;
    len = 4'h9;
    glitch = 1'b0;
    last_data = 8'h00;
    errors = 0;
    checks = 0;
    void'($urandom(24092));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd("reset value", a[2:0], 8'h00);
    end
    check("ferr", {7'h00, ferr}, 8'h00);
    check("done", {7'h00, done}, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      b = 8'($urandom);
      nb = 1'($urandom);
      m2 = m[1:0];
      acc = (m2 != uart_rx_pkg::MODE_SHIFT);
      xb = (m2 == uart_rx_pkg::MODE_8VAR) ? 1'b1 : nb;
      wr(uart_rx_pkg::OFS_CTRL, {m2, 6'h10});
      expect_rx((m2 == uart_rx_pkg::MODE_8VAR) ? {2'b11, b} : {1'b1, nb, b},
        (m2 == uart_rx_pkg::MODE_8VAR) ? 4'h9 : 4'ha, {m2, 3'b010, acc & xb, 1'b0, acc}, acc);
    end
    expect_rx({2'b11, ~b}, 4'ha, {2'b11, 3'b010, xb, 1'b0, 1'b1}, 1'b0);
    $display("test modes done");
    wr(uart_rx_pkg::OFS_CTRL, 8'h50);
    send(10'h3ff, 4'h9, 1'b1);
    rd("ctrl", uart_rx_pkg::OFS_CTRL, 8'h50);
    expect_rx({2'b11, 8'h3c}, 4'h9, 8'h55, 1'b1);
    $display("test false start done");
    wr(uart_rx_pkg::OFS_CTRL, 8'h70);
    // mode bits set before the bit-7 select
    wr(uart_rx_pkg::OFS_PWR, 8'h40);
    expect_rx({2'b10, 8'h96}, 4'h9, 8'hf0, 1'b0);
    check("ferr", {7'h00, ferr}, 8'h01);
    expect_rx({2'b11, 8'h69}, 4'h9, 8'hf5, 1'b1);
    wr(uart_rx_pkg::OFS_CTRL, 8'h50);
    rd("ctrl", uart_rx_pkg::OFS_CTRL, 8'h50);
    check("ferr", {7'h00, ferr}, 8'h00);
    wr(uart_rx_pkg::OFS_PWR, 8'h00);
    $display("test frame error done");
    for (int i = 0; i < 12; i++) begin
      sa = (i == 0) ? 8'h00 : 8'($urandom);
      sm = (i == 0) ? 8'h00 : 8'($urandom);
      r = 8'($urandom);
      case (i % 3)
        0: b = r;
        1: b = sa ^ (r & ~sm);
        default: b = sa | sm | r;
      endcase
      // address bytes carry a one in the ninth bit
      nb = (i % 4 != 3);
      m2 = i[0] ? uart_rx_pkg::MODE_9FIX : uart_rx_pkg::MODE_9VAR;
      acc = nb && ((((b ^ sa) & sm) == 8'h00) || ((~b & (sa | sm)) == 8'h00));
      wr(uart_rx_pkg::OFS_SLAVE_ADDR_REG, sa);
      wr(uart_rx_pkg::OFS_SMASK, sm);
      wr(uart_rx_pkg::OFS_CTRL, {m2, 6'h30});
      rd("mask", uart_rx_pkg::OFS_SMASK, sm);
      expect_rx({1'b1, nb, b}, 4'ha, {m2, 3'b110, acc, 1'b0, acc}, acc);
    end
    // let the last read result reach the monitor before closing
    repeat (2) @(posedge ref_clk_i);
    $display("test address filter done");
    close_out();
  end
endmodule
